// file: hdl/cpm_monitor.sv
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module cpm_monitor (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic REF_TICK_I,
  input wire logic SYS_TICK_I,
  input wire logic PLL_TICK_I,
  input wire logic SYS_FREQ_LOST_I,
  input wire logic PLL_FREQ_LOST_I,
  input wire logic [cpm_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [cpm_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic SYS_PPM_LOST_O,
  output logic PLL_PPM_LOST_O
);
  import cpm_pkg::*;

  // ticks are one-cycle enables standing for edges of the 25 MHz and 125 MHz clocks
  logic [13:0] ref_period;
  logic [15:0] nominal_count;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] sys_capture;
  logic [15:0] pll_capture;
  logic [13:0] ref_cnt;
  logic [15:0] sys_cnt;
  logic [15:0] pll_cnt;
  logic system_ppm_lost_flag;
  logic pll_ppm_lost_flag;
  logic system_frequency_lost_flag;
  logic pll_frequency_lost_flag;
  logic rollover;

  function automatic logic in_range(input logic [15:0] cnt, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (cnt >= lo) || (cnt <= hi);
  endfunction

  function automatic logic [15:0] mon_step(input logic [15:0] cnt, input logic [15:0] top);
    mon_step = (cnt == top) ? 16'h0000 : cnt + 16'h0001;
  endfunction

  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction

  assign rollover = REF_TICK_I && (ref_cnt == 14'h0000);

  // reference counter reloads from the period setting when it reaches zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ref_cnt <= RST_REF_PERIOD;
    end else if (REF_TICK_I) begin
      if (ref_cnt == 14'h0000) begin
        ref_cnt <= ref_period;
      end else begin
        ref_cnt <= ref_cnt - 14'h0001;
      end
    end
  end

  // monitored counters count up and roll back to zero past the nominal count, so a fast
  // clock ends its period small; a tick in the rollover cycle itself is not counted
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sys_cnt <= 16'h0000;
      pll_cnt <= 16'h0000;
    end else begin
      if (rollover) begin
        sys_cnt <= 16'h0000;
      end else if (SYS_TICK_I) begin
        sys_cnt <= mon_step(sys_cnt, nominal_count);
      end
      if (rollover) begin
        pll_cnt <= 16'h0000;
      end else if (PLL_TICK_I) begin
        pll_cnt <= mon_step(pll_cnt, nominal_count);
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sys_capture <= RST_CAPTURE;
      pll_capture <= RST_CAPTURE;
    end else if (rollover) begin
      sys_capture <= sys_cnt;
      pll_capture <= pll_cnt;
    end
  end

  // write channel: accept address and data in either order
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [9:0] wr_idx;
  logic wr_clear;

  assign wr_go = aw_held && w_held && !S_AXI_BVALID_O;
  assign wr_idx = reg_index(aw_addr);
  assign wr_clear = wr_go && (wr_idx == IDX_STATUS);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        case (wr_idx)
          IDX_REF_PERIOD, IDX_NOMINAL, IDX_UPPER, IDX_LOWER, IDX_STATUS,
          IDX_SYS_CAPTURE, IDX_PLL_CAPTURE: S_AXI_BRESP_O <= RESP_OKAY;
          default: S_AXI_BRESP_O <= RESP_SLVERR;
        endcase
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // configuration registers; capture registers ignore writes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ref_period <= RST_REF_PERIOD;
      nominal_count <= RST_NOMINAL;
      upper_limit <= RST_UPPER;
      lower_limit <= RST_LOWER;
    end else if (wr_go) begin
      case (wr_idx)
        IDX_REF_PERIOD: begin
          if (w_strb[0]) ref_period[7:0] <= w_data[7:0];
          if (w_strb[1]) ref_period[13:8] <= w_data[13:8];
        end
        IDX_NOMINAL: begin
          if (w_strb[0]) nominal_count[7:0] <= w_data[7:0];
          if (w_strb[1]) nominal_count[15:8] <= w_data[15:8];
        end
        IDX_UPPER: begin
          if (w_strb[0]) upper_limit[7:0] <= w_data[7:0];
          if (w_strb[1]) upper_limit[15:8] <= w_data[15:8];
        end
        IDX_LOWER: begin
          if (w_strb[0]) lower_limit[7:0] <= w_data[7:0];
          if (w_strb[1]) lower_limit[15:8] <= w_data[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky flags: a new event in the clearing cycle wins over the clear
  logic next_sys_ppm;
  logic next_pll_ppm;
  logic sys_ppm_event;
  logic pll_ppm_event;
  logic clr_sys_ppm;
  logic clr_pll_ppm;
  logic clr_sys_freq;
  logic clr_pll_freq;

  assign sys_ppm_event = rollover && !in_range(sys_cnt, lower_limit, upper_limit);
  assign pll_ppm_event = rollover && !in_range(pll_cnt, lower_limit, upper_limit);
  assign clr_sys_ppm = wr_clear && w_strb[1] && w_data[BIT_SYS_PPM];
  assign clr_pll_ppm = wr_clear && w_strb[0] && w_data[BIT_PLL_PPM];
  assign clr_sys_freq = wr_clear && w_strb[1] && w_data[BIT_SYS_FREQ];
  assign clr_pll_freq = wr_clear && w_strb[0] && w_data[BIT_PLL_FREQ];
  assign next_sys_ppm = sys_ppm_event || (system_ppm_lost_flag && !clr_sys_ppm);
  assign next_pll_ppm = pll_ppm_event || (pll_ppm_lost_flag && !clr_pll_ppm);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      system_ppm_lost_flag <= 1'b0;
      pll_ppm_lost_flag <= 1'b0;
      SYS_PPM_LOST_O <= 1'b0;
      PLL_PPM_LOST_O <= 1'b0;
    end else begin
      system_ppm_lost_flag <= next_sys_ppm;
      pll_ppm_lost_flag <= next_pll_ppm;
      SYS_PPM_LOST_O <= next_sys_ppm;
      PLL_PPM_LOST_O <= next_pll_ppm;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      system_frequency_lost_flag <= 1'b0;
      pll_frequency_lost_flag <= 1'b0;
    end else begin
      system_frequency_lost_flag <= SYS_FREQ_LOST_I ||
        (system_frequency_lost_flag && !clr_sys_freq);
      pll_frequency_lost_flag <= PLL_FREQ_LOST_I || (pll_frequency_lost_flag && !clr_pll_freq);
    end
  end

  // read channel; one outstanding read
  logic [15:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = 16'h0000;
    rd_ok = 1'b1;
    case (reg_index(S_AXI_ARADDR_I))
      IDX_REF_PERIOD: rd_word = {2'b00, ref_period};
      IDX_NOMINAL: rd_word = nominal_count;
      IDX_UPPER: rd_word = upper_limit;
      IDX_LOWER: rd_word = lower_limit;
      IDX_SYS_CAPTURE: rd_word = sys_capture;
      IDX_PLL_CAPTURE: rd_word = pll_capture;
      IDX_STATUS: begin
        rd_word[BIT_SYS_FREQ] = system_frequency_lost_flag;
        rd_word[BIT_SYS_PPM] = system_ppm_lost_flag;
        rd_word[BIT_PLL_FREQ] = pll_frequency_lost_flag;
        rd_word[BIT_PLL_PPM] = pll_ppm_lost_flag;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= {16'h0000, rd_word};
        S_AXI_RRESP_O <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  AST_CAPTURE_SYS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rollover |=> sys_capture == $past(sys_cnt)) else $error("sys capture not latched");
  AST_CAPTURE_PLL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !rollover |=> $stable(pll_capture)) else $error("pll capture moved off rollover");
  AST_RELOAD_MON: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rollover |=> sys_cnt == 16'h0000) else $error("monitor not restarted");
  AST_MON_WRAP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!rollover && SYS_TICK_I && sys_cnt == nominal_count) |=> sys_cnt == 16'h0000)
    else $error("monitor count did not roll back");
  AST_REF_RELOAD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rollover |=> ref_cnt == $past(ref_period)) else $error("reference not reloaded");
  AST_SYS_FLAG_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sys_ppm_event |=> system_ppm_lost_flag && SYS_PPM_LOST_O) else $error("sys flag not set");
  AST_PLL_FLAG_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    pll_ppm_event |=> pll_ppm_lost_flag) else $error("pll flag not set");
  AST_IN_RANGE_QUIET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (rollover && sys_cnt <= upper_limit && !system_ppm_lost_flag) |=> !system_ppm_lost_flag)
    else $error("flag on in-range count");
  AST_UPPER_CMP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (rollover && sys_cnt > upper_limit && sys_cnt < lower_limit) |=> system_ppm_lost_flag)
    else $error("out of range missed");
  AST_FREQ_STICKY: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (system_frequency_lost_flag && !clr_sys_freq) |=> system_frequency_lost_flag)
    else $error("freq flag dropped");
  AST_LOWER_CMP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (rollover && pll_cnt >= lower_limit && !pll_ppm_lost_flag) |=> !pll_ppm_lost_flag)
    else $error("flag on slow in-range count");
  COV_ROLL: cover property (@(posedge CLK_I) disable iff (!RST_N_I) rollover);
  COV_SYS_LOST: cover property (@(posedge CLK_I) disable iff (!RST_N_I) sys_ppm_event);
  COV_CLEAR: cover property (@(posedge CLK_I) disable iff (!RST_N_I) clr_sys_ppm);
endmodule
`default_nettype wire

// file: pkg/cpm_pkg.sv
`default_nettype none
package cpm_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_REF_PERIOD = 10'h1d9;
  localparam logic [9:0] IDX_NOMINAL = 10'h1da;
  localparam logic [9:0] IDX_UPPER = 10'h1db;
  localparam logic [9:0] IDX_LOWER = 10'h1dc;
  localparam logic [9:0] IDX_SYS_CAPTURE = 10'h1dd;
  localparam logic [9:0] IDX_PLL_CAPTURE = 10'h1de;
  localparam logic [9:0] IDX_STATUS = 10'h1d8;
  localparam int ADDR_W = 12;
  localparam logic [13:0] RST_REF_PERIOD = 14'h30d3;
  localparam logic [15:0] RST_NOMINAL = 16'hf423;
  localparam logic [15:0] RST_UPPER = 16'h0044;
  localparam logic [15:0] RST_LOWER = 16'hf3df;
  localparam logic [15:0] RST_CAPTURE = 16'hf423;
  localparam int BIT_PLL_PPM = 5;
  localparam int BIT_PLL_FREQ = 6;
  localparam int BIT_SYS_PPM = 9;
  localparam int BIT_SYS_FREQ = 10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: test/test_clock_ppm_monitor.sv
`default_nettype none
module test_clock_ppm_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import cpm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_t = 1'b0, sys_t = 1'b0, pll_t = 1'b0, sfl = 1'b0, pfl = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, sys_lost, pll_lost;
  int err_total = 0;
  int comparisons = 0;
  int tick_s[4] = '{240, 261, 262, 239};
  int tick_p[4] = '{239, 262, 261, 257};

  always #10 clk = ~clk;

  cpm_monitor i_cpm_monitor (.CLK_I(clk), .RST_N_I(rst_n), .REF_TICK_I(ref_t),
    .SYS_TICK_I(sys_t), .PLL_TICK_I(pll_t), .SYS_FREQ_LOST_I(sfl), .PLL_FREQ_LOST_I(pfl),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .SYS_PPM_LOST_O(sys_lost),
    .PLL_PPM_LOST_O(pll_lost));

  task automatic close_out;
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a response that never comes is counted and ends the run
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n == 100) begin
      err_total++;
      close_out();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n == 100) begin
      err_total++;
      close_out();
    end
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // one reference rollover, ns and np monitored ticks, then a second rollover
  task automatic measure(input int ns, input int np);
    int m;
    m = (ns > np) ? ns : np;
    @(posedge clk);
    ref_t <= 1'b1;
    for (int i = 0; i < m; i++) begin
      @(posedge clk);
      ref_t <= 1'b0;
      sys_t <= (i < ns);
      pll_t <= (i < np);
    end
    @(posedge clk);
    sys_t <= 1'b0;
    pll_t <= 1'b0;
    ref_t <= 1'b1;
    @(posedge clk);
    ref_t <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    logic [15:0] cs, cp;
    logic fs, fp;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    rd(IDX_REF_PERIOD, 32'h30d3, RESP_OKAY);
    rd(IDX_NOMINAL, 32'hf423, RESP_OKAY);
    rd(IDX_UPPER, 32'h44, RESP_OKAY);
    rd(IDX_LOWER, 32'hf3df, RESP_OKAY);
    rd(IDX_SYS_CAPTURE, 32'hf423, RESP_OKAY);
    rd(IDX_PLL_CAPTURE, 32'hf423, RESP_OKAY);
    wr(IDX_SYS_CAPTURE, 32'h1234, 4'hf, RESP_OKAY);
    rd(IDX_SYS_CAPTURE, 32'hf423, RESP_OKAY);
    wr(10'h1df, 32'h1, 4'hf, RESP_SLVERR);
    rd(10'h1df, 32'h0, RESP_SLVERR);
    wr(IDX_NOMINAL, 32'habcd, 4'h1, RESP_OKAY);
    rd(IDX_NOMINAL, 32'hf4cd, RESP_OKAY);
    wr(IDX_REF_PERIOD, 32'h0, 4'hf, RESP_OKAY);
    rd(IDX_REF_PERIOD, 32'h0, RESP_OKAY);
    wr(IDX_NOMINAL, 32'h100, 4'hf, RESP_OKAY);
    wr(IDX_UPPER, 32'h4, 4'hf, RESP_OKAY);
    wr(IDX_LOWER, 32'hf0, 4'hf, RESP_OKAY);
    rd(IDX_UPPER, 32'h4, RESP_OKAY);
    // run the reference down from its reset count so every tick is a rollover
    @(posedge clk);
    ref_t <= 1'b1;
    repeat (12600) @(posedge clk);
    ref_t <= 1'b0;
    // frequency flags stay clear here, so status reads expect only the ppm bits
    for (int r = 0; r < 4; r++) begin
      wr(IDX_STATUS, 32'h220, 4'hf, RESP_OKAY);
      rd(IDX_STATUS, 32'h0, RESP_OKAY);
      measure(tick_s[r], tick_p[r]);
      // with nominal 0x100 the count laps every 257 ticks
      cs = (tick_s[r] > 256) ? 16'(tick_s[r] - 257) : 16'(tick_s[r]);
      cp = (tick_p[r] > 256) ? 16'(tick_p[r] - 257) : 16'(tick_p[r]);
      fs = !(cs >= 16'h00f0 || cs <= 16'h0004);
      fp = !(cp >= 16'h00f0 || cp <= 16'h0004);
      rd(IDX_SYS_CAPTURE, {16'h0, cs}, RESP_OKAY);
      rd(IDX_PLL_CAPTURE, {16'h0, cp}, RESP_OKAY);
      rd(IDX_STATUS, {22'h0, fs, 3'h0, fp, 5'h0}, RESP_OKAY);
      chk({30'h0, sys_lost, pll_lost}, {30'h0, fs, fp});
    end
    @(posedge clk);
    sfl <= 1'b1;
    pfl <= 1'b1;
    @(posedge clk);
    sfl <= 1'b0;
    pfl <= 1'b0;
    rd(IDX_STATUS, 32'h640, RESP_OKAY);
    wr(IDX_STATUS, 32'h400, 4'hf, RESP_OKAY);
    rd(IDX_STATUS, 32'h240, RESP_OKAY);
    wr(IDX_STATUS, 32'h240, 4'hf, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
